// *** dio_cfg.svh ***
`ifndef DIO_CFG_SVH
`define DIO_CFG_SVH

// clock and time base
`define DIO_CLK_PS      4000
`define DIO_MS_PS       1000000000
`define DIO_QUAL_MS     8'hFA
`define DIO_OPCYC_MS    8'hFA
`define DIO_CYC_UNIT_MS 32'h00000064

// register offsets
`define DIO_A_DIFUNC    5'h00
`define DIO_A_CTRL      5'h01
`define DIO_A_ASG1      5'h02
`define DIO_A_ASG2      5'h03
`define DIO_A_SRC1      5'h04
`define DIO_A_SRC2      5'h05
`define DIO_A_MANUAL    5'h06
`define DIO_A_POLARITY  5'h07
`define DIO_A_DADDR     5'h08
`define DIO_A_DCHAN     5'h09
`define DIO_A_BIAS      5'h0A
`define DIO_A_RATIO     5'h0B
`define DIO_A_LIMHI     5'h0C
`define DIO_A_LIMLO     5'h0D
`define DIO_A_STOPMV    5'h0E
`define DIO_A_CYCLE     5'h0F
`define DIO_A_MINONOFF  5'h10
`define DIO_A_DISTATE   5'h11
`define DIO_A_DOSTATE   5'h12
`define DIO_A_ERROR     5'h13

// control fields
`define DIO_CTRL_AREAEN 0
`define DIO_CTRL_DIST   1

// reset values
`define DIO_RST_ADDR    8'hFF
`define DIO_RST_CHAN    7'h01
`define DIO_RST_RATIO   16'h03E8
`define DIO_RST_LIMHI   16'h041A
`define DIO_RST_LIMLO   16'hFFCE
`define DIO_RST_CYCLE   10'h014

// accepted ranges, 17-bit signed
`define DIO_DIFUNC_MAX  17'sh0001D
`define DIO_ASG_MAX     17'sh0000D
`define DIO_ADDR_MIN    17'sh1FFFF
`define DIO_ADDR_MAX    17'sh00063
`define DIO_CHAN_MIN    17'sh00001
`define DIO_BIAS_MAX    17'sh003E8
`define DIO_BIAS_MIN    17'sh1FC18
`define DIO_RATIO_MAX   17'sh0270F
`define DIO_RATIO_MIN   17'sh1D8F1
`define DIO_MV_MAX      17'sh0041A
`define DIO_MV_MIN      17'sh1FFCE
`define DIO_CYCLE_MAX   17'sh003E8
`define DIO_MINOO_MAX   17'sh003E8
`define DIO_ZERO        17'sh00000

// codes
`define DIO_DO_NONE     4'h0
`define DIO_DO_MANUAL   4'hD
`define DIO_ERR_BACKUP  8'h02
`define DIO_RATIO_ONE   32'sh000003E8
`define DIO_ONTIME_DIV  32'sh0000000A

`endif

// *** dio_pkg.sv ***
package dio_pkg;
    typedef logic signed [15:0] dio_val_t;
    typedef enum logic [1:0] {DIO_OK, DIO_FAIL, DIO_HALT} dio_health_t;
endpackage : dio_pkg

// *** dio_output_module.sv ***
`timescale 1ns/1ps
`include "dio_cfg.svh"
// Operation
// [R1] accept a new contact level only after 250 ms of stability
// [R2] contact function code 0 to 29 selects controller functions
// [R3] memory area set signal enable, disabled after reset
// [R4] outputs 1-4 and 5-8 each take an assignment code 0 to 13
// [R5] each group holds a source module address -1 or 0 to 99
// [R6] one manual bit per output: 0 off, 1 on
// [R7] polarity 0 drives directly, 1 inverts the output
// [R8] assigned outputs update once per 250 ms operating cycle
// [R9] distribution select 0 uses assigned signals, 1 the master value
// [R10] master chosen by module address -1..99 and channel 1..99
// [R11] master value scaled by ratio +-9.999 and bias +-100.0 percent
// [R12] value clamped low >= -5.0, high <= 105.0, low <= high
// [R13] in STOP mode the separate stop value is output
// [R14] value becomes time-proportional switching, cycle 0.1-100 s
// [R15] any self-diagnostic error switches every output off
// [R16] backup failure reports error code 2 and stops functions
// [R17] supply or watchdog trip halts with no error number
// [R18] green steady running, green flashing on error, red on abnormality
// [R19] communication lamp green while sending or receiving
// [R20] on-time is value times cycle; short on/off intervals suppressed
module dio_output_module #(
    parameter int MS_CYCLES = `DIO_MS_PS / `DIO_CLK_PS
) (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic [4:0]  regAddr,
    input  wire logic [15:0] regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [15:0] regRdata,
    input  wire logic [7:0]  contactIn,
    output logic      [7:0]  diLevel,
    output logic      [4:0]  diFunc,
    output logic             areaSet,
    output logic      [7:0]  srcAddr1,
    output logic      [3:0]  srcCode1,
    input  wire logic [3:0]  srcSig1,
    output logic      [7:0]  srcAddr2,
    output logic      [3:0]  srcCode2,
    input  wire logic [3:0]  srcSig2,
    output logic      [7:0]  distAddr,
    output logic      [6:0]  distChan,
    input  wire logic [15:0] distMv,
    input  wire logic        ctlStop,
    output logic      [7:0]  doOut,
    input  wire logic        backupFail,
    input  wire logic        supplyTrip,
    input  wire logic        wdogTrip,
    input  wire logic        instAbnormal,
    input  wire logic        commActive,
    output logic             lampGreen,
    output logic             lampRed,
    output logic             lampComm,
    output logic      [7:0]  errCode
);

    function automatic logic inRange(input logic signed [16:0] v,
                                     input logic signed [16:0] lo,
                                     input logic signed [16:0] hi);
        inRange = (v >= lo) && (v <= hi);
    endfunction : inRange

    function automatic logic [3:0] grpSel(input logic [3:0] code,
                                          input logic [3:0] sig,
                                          input logic [3:0] man);
        if (code == `DIO_DO_NONE) begin
            grpSel = 4'h0;
        end else if (code == `DIO_DO_MANUAL) begin
            grpSel = man;
        end else begin
            grpSel = sig;
        end
    endfunction : grpSel

    // time base
    logic [17:0] msCnt_q, msCnt_d;
    logic [7:0]  opCnt_q, opCnt_d;
    logic [16:0] phase_q, phase_d;
    logic [16:0] onMs_q, onMs_d;
    logic        flash_q, flash_d;
    logic        msTick, opTick;

    // registers
    logic [4:0]       diFunc_q, diFunc_d;
    logic [1:0]       ctrl_q, ctrl_d;
    logic [3:0]       asg1_q, asg1_d, asg2_q, asg2_d;
    logic [7:0]       src1_q, src1_d, src2_q, src2_d;
    logic [7:0]       man_q, man_d, pol_q, pol_d;
    logic [7:0]       dAddr_q, dAddr_d;
    logic [6:0]       dChan_q, dChan_d;
    dio_pkg::dio_val_t bias_q, bias_d, ratio_q, ratio_d;
    dio_pkg::dio_val_t hi_q, hi_d, lo_q, lo_d, stop_q, stop_d;
    logic [9:0]       cyc_q, cyc_d, min_q, min_d;
    logic [15:0]      rdata_q, rdata_d;
    logic signed [16:0] wv;

    // outputs and health
    dio_pkg::dio_health_t health_q, health_d;
    logic [7:0] di_q;
    logic [7:0] do_q, do_d;
    logic       green_q, green_d, red_q, red_d, comm_q, comm_d;
    logic       area_q, area_d;
    logic [7:0] err_q, err_d;
    logic       trip, anyFail, pwm;

    // contact qualification
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_qual
            logic [7:0] cnt_q, cnt_d;
            logic       lvl_q, lvl_d;
            always_comb begin
                cnt_d = cnt_q;
                lvl_d = lvl_q;
                if (contactIn[gi] == lvl_q) begin
                    cnt_d = 8'h00;
                end else if (msTick) begin
                    if (cnt_q == `DIO_QUAL_MS - 8'h01) begin
                        lvl_d = contactIn[gi]; // see [R1]
                        cnt_d = 8'h00;
                    end else begin
                        cnt_d = cnt_q + 8'h01;
                    end
                end
            end
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    cnt_q <= 8'h00;
                    lvl_q <= 1'b0;
                end else begin
                    cnt_q <= cnt_d;
                    lvl_q <= lvl_d;
                end
            end
            assign di_q[gi] = lvl_q;
        end
    endgenerate

    // register file
    always_comb begin
        wv       = {regWdata[15], regWdata};
        diFunc_d = diFunc_q;
        ctrl_d   = ctrl_q;
        asg1_d   = asg1_q;
        asg2_d   = asg2_q;
        src1_d   = src1_q;
        src2_d   = src2_q;
        man_d    = man_q;
        pol_d    = pol_q;
        dAddr_d  = dAddr_q;
        dChan_d  = dChan_q;
        bias_d   = bias_q;
        ratio_d  = ratio_q;
        hi_d     = hi_q;
        lo_d     = lo_q;
        stop_d   = stop_q;
        cyc_d    = cyc_q;
        min_d    = min_q;
        rdata_d  = 16'h0000;
        // out-of-range writes are dropped and the old value kept
        if (regWr) begin
            case (regAddr)
                `DIO_A_DIFUNC: if (inRange(wv, `DIO_ZERO, `DIO_DIFUNC_MAX)) begin
                    diFunc_d = regWdata[4:0]; // see [R2]
                end
                `DIO_A_CTRL: ctrl_d = regWdata[1:0]; // see [R3] see [R9]
                `DIO_A_ASG1: if (inRange(wv, `DIO_ZERO, `DIO_ASG_MAX)) begin
                    asg1_d = regWdata[3:0]; // see [R4]
                end
                `DIO_A_ASG2: if (inRange(wv, `DIO_ZERO, `DIO_ASG_MAX)) begin
                    asg2_d = regWdata[3:0]; // see [R4]
                end
                `DIO_A_SRC1: if (inRange(wv, `DIO_ADDR_MIN, `DIO_ADDR_MAX)) begin
                    src1_d = regWdata[7:0]; // see [R5]
                end
                `DIO_A_SRC2: if (inRange(wv, `DIO_ADDR_MIN, `DIO_ADDR_MAX)) begin
                    src2_d = regWdata[7:0]; // see [R5]
                end
                `DIO_A_MANUAL: man_d = regWdata[7:0]; // see [R6]
                `DIO_A_POLARITY: pol_d = regWdata[7:0]; // see [R7]
                `DIO_A_DADDR: if (inRange(wv, `DIO_ADDR_MIN, `DIO_ADDR_MAX)) begin
                    dAddr_d = regWdata[7:0]; // see [R10]
                end
                `DIO_A_DCHAN: if (inRange(wv, `DIO_CHAN_MIN, `DIO_ADDR_MAX)) begin
                    dChan_d = regWdata[6:0]; // see [R10]
                end
                `DIO_A_BIAS: if (inRange(wv, `DIO_BIAS_MIN, `DIO_BIAS_MAX)) begin
                    bias_d = regWdata; // see [R11]
                end
                `DIO_A_RATIO: if (inRange(wv, `DIO_RATIO_MIN, `DIO_RATIO_MAX)) begin
                    ratio_d = regWdata; // see [R11]
                end
                `DIO_A_LIMHI: if (inRange(wv, {lo_q[15], lo_q}, `DIO_MV_MAX)) begin
                    hi_d = regWdata; // see [R12]
                end
                `DIO_A_LIMLO: if (inRange(wv, `DIO_MV_MIN, {hi_q[15], hi_q})) begin
                    lo_d = regWdata; // see [R12]
                end
                `DIO_A_STOPMV: if (inRange(wv, `DIO_MV_MIN, `DIO_MV_MAX)) begin
                    stop_d = regWdata; // see [R13]
                end
                `DIO_A_CYCLE: if (inRange(wv, `DIO_CHAN_MIN, `DIO_CYCLE_MAX)) begin
                    cyc_d = regWdata[9:0]; // see [R14]
                end
                `DIO_A_MINONOFF: if (inRange(wv, `DIO_ZERO, `DIO_MINOO_MAX)) begin
                    min_d = regWdata[9:0]; // see [R14]
                end
                default: ;
            endcase
        end
        if (regRd) begin
            case (regAddr)
                `DIO_A_DIFUNC:   rdata_d = {11'h000, diFunc_q};
                `DIO_A_CTRL:     rdata_d = {14'h0000, ctrl_q};
                `DIO_A_ASG1:     rdata_d = {12'h000, asg1_q};
                `DIO_A_ASG2:     rdata_d = {12'h000, asg2_q};
                `DIO_A_SRC1:     rdata_d = {{8{src1_q[7]}}, src1_q};
                `DIO_A_SRC2:     rdata_d = {{8{src2_q[7]}}, src2_q};
                `DIO_A_MANUAL:   rdata_d = {8'h00, man_q};
                `DIO_A_POLARITY: rdata_d = {8'h00, pol_q};
                `DIO_A_DADDR:    rdata_d = {{8{dAddr_q[7]}}, dAddr_q};
                `DIO_A_DCHAN:    rdata_d = {9'h000, dChan_q};
                `DIO_A_BIAS:     rdata_d = bias_q;
                `DIO_A_RATIO:    rdata_d = ratio_q;
                `DIO_A_LIMHI:    rdata_d = hi_q;
                `DIO_A_LIMLO:    rdata_d = lo_q;
                `DIO_A_STOPMV:   rdata_d = stop_q;
                `DIO_A_CYCLE:    rdata_d = {6'h00, cyc_q};
                `DIO_A_MINONOFF: rdata_d = {6'h00, min_q};
                `DIO_A_DISTATE:  rdata_d = {8'h00, di_q};
                `DIO_A_DOSTATE:  rdata_d = {8'h00, do_q};
                `DIO_A_ERROR:    rdata_d = {6'h00, health_q, err_q};
                default:         rdata_d = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            diFunc_q <= 5'h00;
            ctrl_q   <= 2'h0;
            asg1_q   <= 4'h0;
            asg2_q   <= 4'h0;
            src1_q   <= `DIO_RST_ADDR;
            src2_q   <= `DIO_RST_ADDR;
            man_q    <= 8'h00;
            pol_q    <= 8'h00;
            dAddr_q  <= `DIO_RST_ADDR;
            dChan_q  <= `DIO_RST_CHAN;
            bias_q   <= 16'h0000;
            ratio_q  <= `DIO_RST_RATIO;
            hi_q     <= `DIO_RST_LIMHI;
            lo_q     <= `DIO_RST_LIMLO;
            stop_q   <= 16'h0000;
            cyc_q    <= `DIO_RST_CYCLE;
            min_q    <= 10'h000;
            rdata_q  <= 16'h0000;
        end else begin
            diFunc_q <= diFunc_d;
            ctrl_q   <= ctrl_d;
            asg1_q   <= asg1_d;
            asg2_q   <= asg2_d;
            src1_q   <= src1_d;
            src2_q   <= src2_d;
            man_q    <= man_d;
            pol_q    <= pol_d;
            dAddr_q  <= dAddr_d;
            dChan_q  <= dChan_d;
            bias_q   <= bias_d;
            ratio_q  <= ratio_d;
            hi_q     <= hi_d;
            lo_q     <= lo_d;
            stop_q   <= stop_d;
            cyc_q    <= cyc_d;
            min_q    <= min_d;
            rdata_q  <= rdata_d;
        end
    end

    // distribution value and proportional cycle
    logic signed [31:0] prod, val, onT, cycMs;

    assign msTick = (msCnt_q == 18'(MS_CYCLES - 1));
    assign opTick = msTick && (opCnt_q == `DIO_OPCYC_MS - 8'h01);

    always_comb begin
        prod  = 32'($signed(distMv)) * 32'(ratio_q);
        val   = prod / `DIO_RATIO_ONE + 32'(bias_q); // see [R11]
        if (val > 32'(hi_q)) begin
            val = 32'(hi_q); // see [R12]
        end else if (val < 32'(lo_q)) begin
            val = 32'(lo_q); // see [R12]
        end
        if (ctlStop) begin
            val = 32'(stop_q); // see [R13]
        end
        cycMs = $signed(32'(cyc_q) * `DIO_CYC_UNIT_MS);
        onT   = (val * $signed(32'(cyc_q))) / `DIO_ONTIME_DIV; // see [R20]
        if (onT < 32'sh0) begin
            onT = 32'sh0;
        end else if (onT > cycMs) begin
            onT = cycMs;
        end
        if (onT < 32'(min_q)) begin
            onT = 32'sh0; // see [R20]
        end else if (cycMs - onT < 32'(min_q)) begin
            onT = cycMs; // see [R20]
        end
        msCnt_d = msTick ? 18'h00000 : msCnt_q + 18'h00001;
        opCnt_d = opCnt_q;
        phase_d = phase_q;
        onMs_d  = onMs_q;
        flash_d = flash_q;
        if (msTick) begin
            opCnt_d = opTick ? 8'h00 : opCnt_q + 8'h01;
            phase_d = (32'(phase_q) >= cycMs - 32'sh1) ? 17'h00000 : phase_q + 17'h00001;
        end
        if (opTick) begin
            onMs_d  = onT[16:0]; // see [R14]
            flash_d = !flash_q;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            msCnt_q <= 18'h00000;
            opCnt_q <= 8'h00;
            phase_q <= 17'h00000;
            onMs_q  <= 17'h00000;
            flash_q <= 1'b0;
        end else begin
            msCnt_q <= msCnt_d;
            opCnt_q <= opCnt_d;
            phase_q <= phase_d;
            onMs_q  <= onMs_d;
            flash_q <= flash_d;
        end
    end

    // outputs, health, lamps
    assign trip    = supplyTrip || wdogTrip;
    assign anyFail = trip || backupFail;
    assign pwm     = phase_q < onMs_q; // see [R14]

    always_comb begin
        health_d = health_q;
        case (health_q)
            dio_pkg::DIO_OK: begin
                if (trip) begin
                    health_d = dio_pkg::DIO_HALT; // see [R17]
                end else if (backupFail) begin
                    health_d = dio_pkg::DIO_FAIL; // see [R16]
                end
            end
            dio_pkg::DIO_FAIL: if (trip) begin
                health_d = dio_pkg::DIO_HALT;
            end
            dio_pkg::DIO_HALT: health_d = dio_pkg::DIO_HALT;
            default: health_d = dio_pkg::DIO_OK;
        endcase
        err_d = (health_d == dio_pkg::DIO_FAIL) ? `DIO_ERR_BACKUP : 8'h00; // see [R16] see [R17]
        do_d  = do_q;
        if (health_d != dio_pkg::DIO_OK) begin
            do_d = 8'h00; // see [R15]
        end else if (ctrl_q[`DIO_CTRL_DIST]) begin
            do_d = {8{pwm}} ^ pol_q; // see [R9] see [R7]
        end else if (opTick) begin
            do_d = {grpSel(asg2_q, srcSig2, man_q[7:4]),
                    grpSel(asg1_q, srcSig1, man_q[3:0])} ^ pol_q; // see [R8] see [R6] see [R7]
        end
        case (health_d)
            dio_pkg::DIO_OK:   green_d = 1'b1; // see [R18]
            dio_pkg::DIO_FAIL: green_d = flash_q; // see [R18]
            default:           green_d = 1'b0;
        endcase
        red_d  = instAbnormal; // see [R18]
        comm_d = commActive; // see [R19]
        area_d = ctrl_q[`DIO_CTRL_AREAEN] && di_q[7] && (health_d == dio_pkg::DIO_OK); // see [R3]
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            health_q <= dio_pkg::DIO_OK;
            err_q    <= 8'h00;
            do_q     <= 8'h00;
            green_q  <= 1'b0;
            red_q    <= 1'b0;
            comm_q   <= 1'b0;
            area_q   <= 1'b0;
        end else begin
            health_q <= health_d;
            err_q    <= err_d;
            do_q     <= do_d;
            green_q  <= green_d;
            red_q    <= red_d;
            comm_q   <= comm_d;
            area_q   <= area_d;
        end
    end

    assign regRdata  = rdata_q;
    assign diLevel   = di_q;
    assign diFunc    = diFunc_q;
    assign areaSet   = area_q;
    assign srcAddr1  = src1_q;
    assign srcCode1  = asg1_q;
    assign srcAddr2  = src2_q;
    assign srcCode2  = asg2_q;
    assign distAddr  = dAddr_q;
    assign distChan  = dChan_q;
    assign doOut     = do_q;
    assign lampGreen = green_q;
    assign lampRed   = red_q;
    assign lampComm  = comm_q;
    assign errCode   = err_q;

    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    logic [8:0] hStable;
    always_ff @(posedge clk_sys) begin
        if (rst || contactIn[0] == diLevel[0]) begin
            hStable <= 9'h000;
        end else if (msTick && hStable != 9'h1FF) begin
            hStable <= hStable + 9'h001;
        end
    end

    sequence sDistIdle;
        ctrl_q[`DIO_CTRL_DIST] && pol_q == 8'h00 && onMs_q == 17'h0 && !anyFail;
    endsequence

    chk_di_qual: assert property ($changed(diLevel[0]) |-> $past(hStable) == 9'h0F9) // see [R1]
        else $error("contact level accepted before qualification time");
    chk_func_range: assert property (diFunc <= 5'h1D) // see [R2]
        else $error("contact function code out of range");
    chk_area_gate: assert property (!ctrl_q[`DIO_CTRL_AREAEN] |=> !areaSet) // see [R3]
        else $error("area set signal active while disabled");
    chk_limit_order: assert property (lo_q >= 16'shFFCE && hi_q <= 16'sh041A && lo_q <= hi_q) // see [R12]
        else $error("output limiters out of order");
    chk_do_hold: assert property (!opTick && !ctrl_q[`DIO_CTRL_DIST] && !anyFail
                                  && health_q == dio_pkg::DIO_OK |=> $stable(doOut)) // see [R8]
        else $error("assigned outputs changed outside the operating cycle");
    chk_fail_off: assert property (anyFail |=> doOut == 8'h00 ##1 doOut == 8'h00) // see [R15]
        else $error("outputs not off after self-diagnostic error");
    chk_err_code: assert property (health_q == dio_pkg::DIO_OK && backupFail && !trip
                                   |=> errCode == 8'h02 && lampGreen == $past(flash_q)) // see [R16]
        else $error("backup failure not reported as code 2");
    chk_halt_quiet: assert property (trip |=> errCode == 8'h00 && !lampGreen) // see [R17]
        else $error("halt shows an error number or green lamp");
    chk_lamp_run: assert property (health_d == dio_pkg::DIO_OK |=> lampGreen) // see [R18]
        else $error("green lamp off while running");
    chk_lamp_comm: assert property (commActive |=> lampComm) // see [R19]
        else $error("communication lamp not lit during traffic");
    chk_pwm_idle: assert property (sDistIdle ##1 sDistIdle |-> doOut == 8'h00) // see [R20]
        else $error("output on with zero on-time");

endmodule : dio_output_module

// *** dio_field_model.sv ***
`timescale 1ns/1ps
// contacts settle on the clock; a neighbour answers each group's address and code
module dio_field_model (
    input  wire logic       clk_sys,
    input  wire logic [7:0] contactLvl,
    input  wire logic [7:0] srcAddr1,
    input  wire logic [3:0] srcCode1,
    input  wire logic [7:0] srcAddr2,
    input  wire logic [3:0] srcCode2,
    output logic      [7:0] contactIn,
    output logic      [3:0] srcSig1,
    output logic      [3:0] srcSig2
);
    always_ff @(posedge clk_sys) begin
        contactIn <= contactLvl;
    end
    assign srcSig1 = srcAddr1[3:0] ^ srcCode1;
    assign srcSig2 = srcAddr2[3:0] ^ srcCode2;
endmodule : dio_field_model

// *** dio_output_module_tb.sv ***
`timescale 1ns/1ps
module dio_output_module_tb;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic [4:0]  regAddr = 5'h00;
    logic [15:0] regWdata = 16'h0000;
    logic        regWr = 1'b0;
    logic        regRd = 1'b0;
    logic [15:0] regRdata, distMv = 16'h01F4;
    logic [7:0]  contactLvl = 8'h00, contactIn, diLevel, srcAddr1, srcAddr2, distAddr, doOut;
    logic [7:0]  errCode;
    logic [4:0]  diFunc;
    logic [6:0]  distChan;
    logic [3:0]  srcCode1, srcCode2, srcSig1, srcSig2;
    logic        areaSet, lampGreen, lampRed, lampComm;
    logic        ctlStop = 1'b0, backupFail = 1'b0, supplyTrip = 1'b0;
    logic        wdogTrip = 1'b0, instAbnormal = 1'b0, commActive = 1'b0;
    int          errCount = 0;
    int          cmpCount = 0;
    always #2 clk_sys = ~clk_sys;
    dio_output_module #(.MS_CYCLES(4)) dut_u (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .contactIn(contactIn), .diLevel(diLevel), .diFunc(diFunc), .areaSet(areaSet),
        .srcAddr1(srcAddr1), .srcCode1(srcCode1), .srcSig1(srcSig1), .srcAddr2(srcAddr2),
        .srcCode2(srcCode2), .srcSig2(srcSig2), .distAddr(distAddr), .distChan(distChan),
        .distMv(distMv), .ctlStop(ctlStop), .doOut(doOut), .backupFail(backupFail),
        .supplyTrip(supplyTrip), .wdogTrip(wdogTrip), .instAbnormal(instAbnormal),
        .commActive(commActive), .lampGreen(lampGreen), .lampRed(lampRed),
        .lampComm(lampComm), .errCode(errCode));
    dio_field_model fld_u (.clk_sys(clk_sys), .contactLvl(contactLvl), .srcAddr1(srcAddr1),
        .srcCode1(srcCode1), .srcAddr2(srcAddr2), .srcCode2(srcCode2),
        .contactIn(contactIn), .srcSig1(srcSig1), .srcSig2(srcSig2));
    task automatic endOfTest();
        $display("comparisons %0d mismatches %0d", cmpCount, errCount);
        if (errCount == 0 && cmpCount > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : endOfTest
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmpCount++;
        if (got !== exp) begin
            errCount++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        @(posedge clk_sys);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRd <= 1'b0;
        @(negedge clk_sys);
        chk("regRdata", exp, regRdata);
    endtask : rd
    task automatic doRst();
        rst <= 1'b1;
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (2) @(negedge clk_sys);
    endtask : doRst
    task automatic waitDo(input logic [7:0] exp);
        int n = 0;
        while (doOut !== exp && n < 1200) begin
            @(negedge clk_sys);
            n++;
        end
        chk("doOut", {8'h00, exp}, {8'h00, doOut});
        if (n >= 1200) endOfTest();
    endtask : waitDo
    task automatic measure(input int exp);
        int cnt = 0;
        repeat (1100) @(negedge clk_sys);
        repeat (400) begin
            @(negedge clk_sys);
            cnt += int'(doOut[0]);
        end
        chk("onCycles", 16'(exp), 16'(cnt));
    endtask : measure
    task automatic testRegs();
        chk("lampGreen", 16'h0001, {15'h0000, lampGreen});
        rd(5'h0B, 16'h03E8);
        rd(5'h0C, 16'h041A);
        rd(5'h0D, 16'hFFCE);
        rd(5'h0F, 16'h0014);
        rd(5'h01, 16'h0000);
        rd(5'h1F, 16'h0000);
        wr(5'h02, 16'h000E);
        rd(5'h02, 16'h0000);
        wr(5'h04, 16'hFFFF);
        rd(5'h04, 16'hFFFF);
        wr(5'h0C, 16'h041B);
        rd(5'h0C, 16'h041A);
        wr(5'h00, 16'h001D);
        wr(5'h00, 16'h001E);
        wr(5'h08, 16'h0063);
        wr(5'h09, 16'h0000);
        rd(5'h00, 16'h001D);
        chk("diFunc", 16'h001D, {11'h000, diFunc});
        chk("distAddr", 16'h0063, {8'h00, distAddr});
        chk("distChan", 16'h0001, {9'h000, distChan});
        chk("srcAddr1", 16'h00FF, {8'h00, srcAddr1});
    endtask : testRegs
    task automatic testQual();
        contactLvl <= 8'h81;
        repeat (980) @(negedge clk_sys);
        chk("diLevel", 16'h0000, {8'h00, diLevel});
        repeat (50) @(negedge clk_sys);
        chk("diLevel", 16'h0081, {8'h00, diLevel});
        chk("areaSet", 16'h0000, {15'h0000, areaSet});
        wr(5'h01, 16'h0001);
        repeat (2) @(negedge clk_sys);
        chk("areaSet", 16'h0001, {15'h0000, areaSet});
    endtask : testQual
    task automatic testDo();
        wr(5'h02, 16'h000D);
        wr(5'h06, 16'h0005);
        wr(5'h07, 16'h0080);
        wr(5'h03, 16'h0003);
        wr(5'h05, 16'h0005);
        waitDo(8'hE5);
    endtask : testDo
    task automatic testDist();
        wr(5'h07, 16'h0000);
        wr(5'h0F, 16'h0001);
        wr(5'h0A, 16'h0064);
        wr(5'h01, 16'h0002);
        measure(240);
        wr(5'h0B, 16'h07D0);
        measure(400);
        @(posedge clk_sys);
        ctlStop <= 1'b1;
        measure(0);
    endtask : testDist
    task automatic testHealth();
        @(posedge clk_sys);
        commActive <= 1'b1;
        instAbnormal <= 1'b1;
        backupFail <= 1'b1;
        repeat (3) @(negedge clk_sys);
        chk("lampComm", 16'h0001, {15'h0000, lampComm});
        chk("lampRed", 16'h0001, {15'h0000, lampRed});
        chk("doOut", 16'h0000, {8'h00, doOut});
        chk("errCode", 16'h0002, {8'h00, errCode});
        rd(5'h13, 16'h0102);
        @(posedge clk_sys);
        backupFail <= 1'b0;
        doRst();
        @(posedge clk_sys);
        supplyTrip <= 1'b1;
        repeat (3) @(negedge clk_sys);
        chk("errCode", 16'h0000, {8'h00, errCode});
        chk("lampGreen", 16'h0000, {15'h0000, lampGreen});
    endtask : testHealth
    initial begin
        doRst();
        testRegs();
        testQual();
        testDo();
        testDist();
        testHealth();
        endOfTest();
    end
endmodule : dio_output_module_tb
